// [ocd_pkg.sv]
// Package: opcode decode types, encodings and timing constants
package ocd_pkg;

	// Opcodes with a fixed meaning in the upper half of the map
	localparam logic [7:0] OPC_TRAP     = 8'ha5;
	localparam logic [7:0] OPC_MUL      = 8'ha4;
	localparam logic [7:0] OPC_COMPARE_JUMP_NOT_EQUAL_IMM = 8'hb4;
	localparam logic [7:0] OPC_INC_DATA_POINTER = 8'ha3;
	localparam logic [7:0] OPC_CPL_C    = 8'hb3;
	localparam logic [7:0] OPC_SWAP     = 8'hc4;
	localparam logic [7:0] OPC_DA       = 8'hd4;
	localparam logic [7:0] OPC_CLR_A    = 8'he4;
	localparam logic [7:0] OPC_CPL_A    = 8'hf4;

	// Field positions inside the opcode byte
	localparam int REG_LSB  = 0;
	localparam int ROW_ABSOLUTE_JUMP_11BIT = 4'h1;

	// External move timing: a write costs one cycle more than a read
	localparam logic [3:0] EXT_WR_EXTRA = 4'h1;
	localparam logic [3:0] EXT_RD_BASE  = 4'h3;
	localparam logic [3:0] EXT_WR_BASE  = 4'h4;

	// Operation classes
	typedef enum logic [5:0] {
		OP_LOWER, OP_SJMP, OP_ABSOLUTE_JUMP_11BIT, OP_ABSOLUTE_CALL_11BIT, OP_ANL_C, OP_ORL_C, OP_MOV_C_BIT,
		OP_MOV_BIT_C, OP_MOVC, OP_DIV, OP_MUL, OP_MOV_DIR, OP_MOV_DATA_POINTER,
		OP_SUBTRACT_WITH_BORROW, OP_INC_DATA_POINTER, OP_TRAP, OP_MOV_IND, OP_MOV_REG, OP_CPL_BIT,
		OP_CPL_C, OP_COMPARE_JUMP_NOT_EQUAL, OP_PUSH, OP_POP, OP_CLR_BIT, OP_SET_BIT, OP_CLR_C,
		OP_SET_C, OP_SWAP, OP_DA, OP_XCH, OP_XCHD, OP_DECREMENT_JUMP_NONZERO, OP_EXT_RD,
		OP_EXT_WR, OP_CLR_A, OP_CPL_A, OP_MOV_A
	} ocd_op_t;

	// Operand source or destination
	typedef enum logic [2:0] {
		OPND_NONE, OPND_REG, OPND_IND, OPND_DIR, OPND_IMM, OPND_DATA_POINTER, OPND_BIT
	} ocd_opnd_t;

	// How carry, overflow and auxiliary carry are updated
	typedef enum logic [2:0] {
		FM_NONE, FM_ALL, FM_MULDIV, FM_CY, FM_CY_SET, FM_CY_CLR, FM_CY_CPL
	} ocd_fmode_t;

	// External move sequencer, Gray along take-address-wait-data
	typedef enum logic [1:0] {
		EX_IDLE = 2'b00,
		EX_ADDR = 2'b01,
		EX_WAIT = 2'b11,
		EX_DATA = 2'b10
	} ocd_ext_st_t;

	// Carry, overflow and auxiliary carry bundle
	typedef struct packed {
		logic carry_flag;
		logic overflow_flag;
		logic aux_carry_flag;
	} ocd_flags_t;

	localparam ocd_flags_t FLAGS_RST = '0;

	// Decoded instruction
	typedef struct packed {
		ocd_op_t    op;
		ocd_opnd_t  opnd;
		logic [2:0] reg_idx;
		logic [2:0] addr_hi;
		ocd_fmode_t fmode;
	} ocd_dec_t;

endpackage

// [ocd_decode.sv]
// Opcode decoder, flag update and external data move sequencer
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - Opcode A5H decodes as a trap into the on-chip debug logic.
// - Executing one instruction overlaps the fetch of the next one.
// - Only flags marked affected update from the result; others hold.
// - Multiply and divide clear carry, take overflow from the result, keep auxiliary carry.
// - Decimal adjust, compare-jump, carry-bit ops: carry only.
// - A4H is multiply accumulator by B; B4H compares immediate, jumps.
// - A3H increments the 16-bit data pointer; B3H complements carry.
// - External reads at E0H, E2H, E3H; writes at F0H, F2H, F3H.
// - C4H swaps accumulator nibbles; D4H decimal adjusts the accumulator.
// - 88H-8FH move register to direct; 98H-9FH subtract with borrow.
// - Row 1H: even high nibble absolute jump, odd absolute call.
// - C8H-CFH exchange accumulator with register; D8H-DFH decrement, jump.
// - C0H pushes a direct byte; D0H pops into a direct byte.
// - C2H clear bit, D2H set bit, B2H complement bit, C3H/D3H carry.
// - E8H-EFH copy register to accumulator; F8H-FFH the reverse.
// - A8H-AFH load register from direct; B8H-BFH compare register, jump.
// - External reads take zero to seven stretch cycles.
// - External writes take one to eight stretch cycles.
// - External read lasts 3 to 10 cycles, write 4 to 11.
module ocd_decode (
	// Clock and reset
	input  wire logic               clk_sys_i,
	input  wire logic               rst_b_i,
	// Fetched opcode
	input  wire logic               instr_valid_i,
	input  wire logic [7:0]         opcode_i,
	// Operand values
	input  wire logic [7:0]         acc_i,
	input  wire logic [15:0]        data_pointer_i,
	input  wire logic [7:0]         r0_i,
	input  wire logic [7:0]         r1_i,
	// Computed flag results of the executing instruction
	input  wire ocd_pkg::ocd_flags_t alu_flags_i,
	// Stretch configuration
	input  wire logic [2:0]         stretch_cfg_i,
	// External data memory read data
	input  wire logic [7:0]         ext_rdata_i,
	// Fetch and execute
	output logic                    fetch_next_o,
	output logic                    busy_o,
	output logic                    exec_valid_o,
	output ocd_pkg::ocd_dec_t       exec_dec_o,
	output logic                    debug_trap_o,
	output ocd_pkg::ocd_flags_t     flags_o,
	// External data memory
	output logic [15:0]             ext_addr_o,
	output logic                    ext_rd_o,
	output logic                    ext_we_o,
	output logic [7:0]              ext_wdata_o,
	output logic                    acc_load_o,
	output logic [7:0]              acc_data_o,
	output logic                    ext_done_o
);

	////////////////////////////////////////////////////////////////////////
	// Decode table for the upper half of the opcode map
	function automatic ocd_pkg::ocd_dec_t decode(input logic [7:0] opc);
		ocd_pkg::ocd_dec_t d;
		d = '{op: ocd_pkg::OP_LOWER, opnd: ocd_pkg::OPND_NONE,
			reg_idx: opc[2:0], addr_hi: opc[7:5], fmode: ocd_pkg::FM_NONE};
		if (opc[3:0] == 4'(ocd_pkg::ROW_ABSOLUTE_JUMP_11BIT))
			d.op = opc[4] ? ocd_pkg::OP_ABSOLUTE_CALL_11BIT : ocd_pkg::OP_ABSOLUTE_JUMP_11BIT;
		else if (opc[7] && opc[3])
		begin
			d.opnd = ocd_pkg::OPND_REG;
			unique case (opc[6:4])
				3'h0: d.op = ocd_pkg::OP_MOV_DIR;
				3'h1: {d.op, d.fmode} = {ocd_pkg::OP_SUBTRACT_WITH_BORROW, ocd_pkg::FM_ALL};
				3'h2: d.op = ocd_pkg::OP_MOV_REG;
				3'h3: {d.op, d.fmode} = {ocd_pkg::OP_COMPARE_JUMP_NOT_EQUAL, ocd_pkg::FM_CY};
				3'h4: d.op = ocd_pkg::OP_XCH;
				3'h5: d.op = ocd_pkg::OP_DECREMENT_JUMP_NONZERO;
				3'h6: d.op = ocd_pkg::OP_MOV_A;
				3'h7: d.op = ocd_pkg::OP_MOV_REG;
			endcase
		end
		else if (opc[7])
		begin
			d.opnd = (opc[3:1] == 3'h3) ? ocd_pkg::OPND_IND
				: ocd_pkg::OPND_DIR;
			unique casez (opc)
				8'h80: d.op = ocd_pkg::OP_SJMP;
				8'h82: {d.op, d.fmode} = {ocd_pkg::OP_ANL_C, ocd_pkg::FM_CY};
				8'h83, 8'h93: d.op = ocd_pkg::OP_MOVC;
				8'h84: {d.op, d.fmode} = {ocd_pkg::OP_DIV, ocd_pkg::FM_MULDIV};
				8'h85, 8'h86, 8'h87: d.op = ocd_pkg::OP_MOV_DIR;
				8'h90: {d.op, d.opnd} = {ocd_pkg::OP_MOV_DATA_POINTER,
					ocd_pkg::OPND_DATA_POINTER};
				8'h92: {d.op, d.opnd} = {ocd_pkg::OP_MOV_BIT_C,
					ocd_pkg::OPND_BIT};
				8'h94, 8'h95, 8'h96, 8'h97:
					{d.op, d.fmode} = {ocd_pkg::OP_SUBTRACT_WITH_BORROW, ocd_pkg::FM_ALL};
				8'ha0, 8'hb0: {d.op, d.fmode, d.opnd} = {(opc[4] ?
					ocd_pkg::OP_ANL_C : ocd_pkg::OP_ORL_C), ocd_pkg::FM_CY,
					ocd_pkg::OPND_BIT};
				8'ha2: {d.op, d.fmode, d.opnd} = {ocd_pkg::OP_MOV_C_BIT,
					ocd_pkg::FM_CY, ocd_pkg::OPND_BIT};
				ocd_pkg::OPC_INC_DATA_POINTER: {d.op, d.opnd} = {
					ocd_pkg::OP_INC_DATA_POINTER, ocd_pkg::OPND_DATA_POINTER};
				ocd_pkg::OPC_MUL: {d.op, d.fmode} = {ocd_pkg::OP_MUL,
					ocd_pkg::FM_MULDIV};
				ocd_pkg::OPC_TRAP: {d.op, d.opnd} = {ocd_pkg::OP_TRAP,
					ocd_pkg::OPND_NONE};
				8'ha6, 8'ha7: d.op = ocd_pkg::OP_MOV_IND;
				8'hb2: {d.op, d.opnd} = {ocd_pkg::OP_CPL_BIT,
					ocd_pkg::OPND_BIT};
				ocd_pkg::OPC_CPL_C: {d.op, d.fmode} = {ocd_pkg::OP_CPL_C,
					ocd_pkg::FM_CY_CPL};
				ocd_pkg::OPC_COMPARE_JUMP_NOT_EQUAL_IMM: {d.op, d.fmode, d.opnd} = {
					ocd_pkg::OP_COMPARE_JUMP_NOT_EQUAL, ocd_pkg::FM_CY,
					ocd_pkg::OPND_IMM};
				8'hb5, 8'hb6, 8'hb7: {d.op, d.fmode} = {ocd_pkg::OP_COMPARE_JUMP_NOT_EQUAL,
					ocd_pkg::FM_CY};
				8'hc0: d.op = ocd_pkg::OP_PUSH;
				8'hd0: d.op = ocd_pkg::OP_POP;
				8'hc2: {d.op, d.opnd} = {ocd_pkg::OP_CLR_BIT,
					ocd_pkg::OPND_BIT};
				8'hd2: {d.op, d.opnd} = {ocd_pkg::OP_SET_BIT,
					ocd_pkg::OPND_BIT};
				8'hc3: {d.op, d.fmode} = {ocd_pkg::OP_CLR_C,
					ocd_pkg::FM_CY_CLR};
				8'hd3: {d.op, d.fmode} = {ocd_pkg::OP_SET_C,
					ocd_pkg::FM_CY_SET};
				ocd_pkg::OPC_SWAP: {d.op, d.opnd} = {ocd_pkg::OP_SWAP,
					ocd_pkg::OPND_NONE};
				ocd_pkg::OPC_DA: {d.op, d.fmode, d.opnd} = {ocd_pkg::OP_DA,
					ocd_pkg::FM_CY, ocd_pkg::OPND_NONE};
				8'hc5, 8'hc6, 8'hc7: d.op = ocd_pkg::OP_XCH;
				8'hd5: d.op = ocd_pkg::OP_DECREMENT_JUMP_NONZERO;
				8'hd6, 8'hd7: d.op = ocd_pkg::OP_XCHD;
				8'he0, 8'he2, 8'he3: {d.op, d.opnd} = {ocd_pkg::OP_EXT_RD,
					(opc[1] ? ocd_pkg::OPND_IND : ocd_pkg::OPND_DATA_POINTER)};
				8'hf0, 8'hf2, 8'hf3: {d.op, d.opnd} = {ocd_pkg::OP_EXT_WR,
					(opc[1] ? ocd_pkg::OPND_IND : ocd_pkg::OPND_DATA_POINTER)};
				ocd_pkg::OPC_CLR_A: {d.op, d.opnd} = {ocd_pkg::OP_CLR_A,
					ocd_pkg::OPND_NONE};
				ocd_pkg::OPC_CPL_A: {d.op, d.opnd} = {ocd_pkg::OP_CPL_A,
					ocd_pkg::OPND_NONE};
				8'he5, 8'he6, 8'he7: d.op = ocd_pkg::OP_MOV_A;
				8'hf5, 8'hf6, 8'hf7: d.op = ocd_pkg::OP_MOV_DIR;
				default: d.op = ocd_pkg::OP_LOWER;
			endcase
		end
		return d;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Take and execute stage
	ocd_pkg::ocd_ext_st_t ext_st_q, ext_st_d;
	ocd_pkg::ocd_dec_t    dec_w, exec_q;
	ocd_pkg::ocd_flags_t  flags_q, flags_d;
	logic                 take_w, is_rd_w, is_wr_w, exec_valid_q, trap_q;
	logic                 wr_q, acc_load_q, done_q, rd_q, we_q;
	logic [3:0]           cnt_q, cnt_d;
	logic [15:0]          addr_q;
	logic [7:0]           wdata_q, rdata_q;
	logic [7:0]           ind_w;

	// An opcode is taken while no external move holds the core
	assign dec_w        = decode(opcode_i);
	assign take_w       = instr_valid_i && (ext_st_q == ocd_pkg::EX_IDLE);
	assign fetch_next_o = take_w;
	assign busy_o       = (ext_st_q != ocd_pkg::EX_IDLE);
	assign is_rd_w      = take_w && (dec_w.op == ocd_pkg::OP_EXT_RD);
	assign is_wr_w      = take_w && (dec_w.op == ocd_pkg::OP_EXT_WR);
	assign ind_w        = opcode_i[0] ? r1_i : r0_i;

	// Decoded word is executed in the cycle that fetches the next opcode
	always_ff @(posedge clk_sys_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			exec_valid_q <= 1'b0;
			exec_q       <= '0;
			trap_q       <= 1'b0;
		end
		else
		begin
			exec_valid_q <= take_w;
			exec_q       <= take_w ? dec_w : exec_q;
			trap_q       <= take_w && (dec_w.op == ocd_pkg::OP_TRAP);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Carry, overflow and auxiliary carry update
	always_comb
	begin
		flags_d = flags_q;
		if (exec_valid_q)
		begin
			unique case (exec_q.fmode)
				ocd_pkg::FM_NONE:   flags_d = flags_q;
				ocd_pkg::FM_ALL:    flags_d = alu_flags_i;
				ocd_pkg::FM_MULDIV:
				begin
					flags_d.carry_flag    = 1'b0;
					flags_d.overflow_flag = alu_flags_i.overflow_flag;
				end
				ocd_pkg::FM_CY:
					flags_d.carry_flag = alu_flags_i.carry_flag;
				ocd_pkg::FM_CY_SET: flags_d.carry_flag = 1'b1;
				ocd_pkg::FM_CY_CLR: flags_d.carry_flag = 1'b0;
				ocd_pkg::FM_CY_CPL:
					flags_d.carry_flag = ~flags_q.carry_flag;
				default:            flags_d = flags_q;
			endcase
		end
	end

	// Flag register
	always_ff @(posedge clk_sys_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			flags_q <= ocd_pkg::FLAGS_RST;
		else
			flags_q <= flags_d;
	end

	////////////////////////////////////////////////////////////////////////
	// External data move sequencer
	always_comb
	begin
		ext_st_d = ext_st_q;
		cnt_d    = cnt_q;
		unique case (ext_st_q)
			ocd_pkg::EX_IDLE:
			begin
				if (is_rd_w || is_wr_w)
				begin
					ext_st_d = ocd_pkg::EX_ADDR;
					cnt_d    = {1'b0, stretch_cfg_i} +
						(is_wr_w ? ocd_pkg::EXT_WR_EXTRA : 4'h0);
				end
			end
			ocd_pkg::EX_ADDR:
				ext_st_d = (cnt_q == 4'h0) ? ocd_pkg::EX_DATA
					: ocd_pkg::EX_WAIT;
			ocd_pkg::EX_WAIT:
			begin
				cnt_d = cnt_q - 4'h1;
				if (cnt_q == 4'h1)
					ext_st_d = ocd_pkg::EX_DATA;
			end
			ocd_pkg::EX_DATA:   ext_st_d = ocd_pkg::EX_IDLE;
		endcase
	end

	// Sequencer state, address, strobes and captured read data
	always_ff @(posedge clk_sys_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			ext_st_q   <= ocd_pkg::EX_IDLE;
			cnt_q      <= 4'h0;
			addr_q     <= 16'h0000;
			wdata_q    <= 8'h00;
			wr_q       <= 1'b0;
			rd_q       <= 1'b0;
			we_q       <= 1'b0;
			rdata_q    <= 8'h00;
			acc_load_q <= 1'b0;
			done_q     <= 1'b0;
		end
		else
		begin
			ext_st_q <= ext_st_d;
			cnt_q    <= cnt_d;
			if (is_rd_w || is_wr_w)
			begin
				addr_q  <= dec_w.opnd == ocd_pkg::OPND_DATA_POINTER ? data_pointer_i
					: {8'h00, ind_w};
				wdata_q <= acc_i;
				wr_q    <= is_wr_w;
			end
			rd_q       <= (ext_st_d != ocd_pkg::EX_IDLE) &&
				(ext_st_q == ocd_pkg::EX_IDLE ? is_rd_w : !wr_q);
			we_q       <= (ext_st_d != ocd_pkg::EX_IDLE) &&
				(ext_st_q == ocd_pkg::EX_IDLE ? is_wr_w : wr_q);
			rdata_q    <= (ext_st_q == ocd_pkg::EX_DATA && !wr_q)
				? ext_rdata_i : rdata_q;
			acc_load_q <= (ext_st_q == ocd_pkg::EX_DATA) && !wr_q;
			done_q     <= (ext_st_q == ocd_pkg::EX_DATA);
		end
	end

	// Output drive
	assign exec_valid_o = exec_valid_q;
	assign exec_dec_o   = exec_q;
	assign debug_trap_o = trap_q;
	assign flags_o      = flags_q;
	assign ext_addr_o   = addr_q;
	assign ext_rd_o     = rd_q;
	assign ext_we_o     = we_q;
	assign ext_wdata_o  = wdata_q;
	assign acc_load_o   = acc_load_q;
	assign acc_data_o   = rdata_q;
	assign ext_done_o   = done_q;

	////////////////////////////////////////////////////////////////////////
	// Checks: move length measured from the take cycle
	logic [3:0] len_q;
	logic [2:0] str_q;
	always_ff @(posedge clk_sys_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			len_q <= 4'h0;
			str_q <= 3'h0;
		end
		else
		begin
			len_q <= take_w ? 4'h1 : len_q + 4'h1;
			str_q <= (is_rd_w || is_wr_w) ? stretch_cfg_i : str_q;
		end
	end

	property p_trap;
		@(posedge clk_sys_i) disable iff (!rst_b_i)
		take_w && opcode_i == ocd_pkg::OPC_TRAP |=> debug_trap_o;
	endproperty
	a_trap: assert property (p_trap) else $error("trap not raised");

	property p_overlap;
		@(posedge clk_sys_i) disable iff (!rst_b_i)
		take_w |=> exec_valid_o && exec_dec_o == $past(dec_w);
	endproperty
	a_overlap: assert property (p_overlap) else $error("exec lag");

	property p_noflag;
		@(posedge clk_sys_i) disable iff (!rst_b_i)
		exec_valid_o && exec_dec_o.fmode == ocd_pkg::FM_NONE
		|=> $stable(flags_o);
	endproperty
	a_noflag: assert property (p_noflag) else $error("flags moved");

	property p_muldiv;
		@(posedge clk_sys_i) disable iff (!rst_b_i)
		exec_valid_o && exec_dec_o.fmode == ocd_pkg::FM_MULDIV
		|=> !flags_o.carry_flag && $stable(flags_o.aux_carry_flag)
		&& flags_o.overflow_flag == $past(alu_flags_i.overflow_flag);
	endproperty
	a_muldiv: assert property (p_muldiv) else $error("mul flags");

	property p_cyonly;
		@(posedge clk_sys_i) disable iff (!rst_b_i)
		exec_valid_o && exec_dec_o.fmode == ocd_pkg::FM_CY
		|=> $stable(flags_o.overflow_flag) && $stable(flags_o.aux_carry_flag)
		&& flags_o.carry_flag == $past(alu_flags_i.carry_flag);
	endproperty
	a_cyonly: assert property (p_cyonly) else $error("carry only");

	property p_rd_len;
		@(posedge clk_sys_i) disable iff (!rst_b_i)
		acc_load_o |-> len_q == ocd_pkg::EXT_RD_BASE + {1'b0, str_q};
	endproperty
	a_rd_len: assert property (p_rd_len) else $error("read length");

	property p_wr_len;
		@(posedge clk_sys_i) disable iff (!rst_b_i)
		ext_done_o && !acc_load_o
		|-> len_q == ocd_pkg::EXT_WR_BASE + {1'b0, str_q};
	endproperty
	a_wr_len: assert property (p_wr_len) else $error("write length");

	property p_wr_strobe;
		@(posedge clk_sys_i) disable iff (!rst_b_i)
		is_wr_w |=> ext_we_o && !ext_rd_o;
	endproperty
	a_wr_strobe: assert property (p_wr_strobe) else $error("we");

	property p_busy;
		@(posedge clk_sys_i) disable iff (!rst_b_i)
		is_rd_w |=> busy_o [*2];
	endproperty
	a_busy: assert property (p_busy) else $error("stall short");

	property p_absolute_jump_11bit;
		@(posedge clk_sys_i) disable iff (!rst_b_i)
		take_w && opcode_i[3:0] == 4'h1 |=> exec_dec_o.addr_hi
		== $past(opcode_i[7:5]) && (exec_dec_o.op == ocd_pkg::OP_ABSOLUTE_CALL_11BIT)
		== $past(opcode_i[4]);
	endproperty
	a_absolute_jump_11bit: assert property (p_absolute_jump_11bit) else $error("abs jump");

	c_trap: cover property (@(posedge clk_sys_i) debug_trap_o);
	c_rd7: cover property (@(posedge clk_sys_i) acc_load_o && str_q == 3'h7);
	c_wr0: cover property (@(posedge clk_sys_i)
		ext_done_o && !acc_load_o && str_q == 3'h0);
	c_mul: cover property (@(posedge clk_sys_i)
		exec_valid_o && exec_dec_o.op == ocd_pkg::OP_MUL);

endmodule

// [ocd_ext_mem.sv]
// External data memory model facing the decoder's move port
`timescale 1ns/100ps
module ocd_ext_mem (
	// Clock
	input  wire logic        clk_sys_i,
	// Move port
	input  wire logic [15:0] ext_addr_i,
	input  wire logic        ext_rd_i,
	input  wire logic        ext_we_i,
	input  wire logic [7:0]  ext_wdata_i,
	// Read data
	output logic [7:0]       ext_rdata_o
);
	logic [7:0] mem [256];
	logic [7:0] last_q;
	wire        ram_cs = ext_we_i & clk_sys_i;

	// Seeded content that the bench mirrors
	initial
	begin
		for (int i = 0; i < 256; i++)
			mem[i] = 8'(i) ^ 8'h3c;
		last_q = 8'h00;
	end

	// Write on the rising edge of the chip select made from strobe and clock
	always @(posedge ram_cs)
		mem[ext_addr_i[7:0]] <= ext_wdata_i;

	// Released bus shows a value that changes every cycle
	always_comb
	begin
		if (ext_rd_i)
			ext_rdata_o = mem[ext_addr_i[7:0]];
		else
			ext_rdata_o = ~last_q;
	end

	always @(posedge clk_sys_i)
		last_q <= ext_rdata_o;
endmodule

// [ocd_decode_tb.sv]
// Self-checking bench for the opcode decoder
`timescale 1ns/100ps
module ocd_decode_tb;
	typedef struct packed {
		logic                chk_op;
		logic                chk_reg;
		ocd_pkg::ocd_op_t    op;
		logic [2:0]          reg_idx;
		logic [2:0]          addr_hi;
		logic                trap;
		ocd_pkg::ocd_flags_t flags;
	} ocd_note_t;
	logic                clk_sys_i, rst_b_i, instr_valid_i, flag_chk;
	logic [7:0]          opcode_i, acc_i, r0_i, r1_i, ext_rdata_i;
	logic [7:0]          v_acc, v_r0, v_r1, ext_wdata_o, acc_data_o;
	logic [15:0]         data_pointer_i, v_data_pointer, ext_addr_o;
	ocd_pkg::ocd_flags_t alu_flags_i, flags_o, exp_f, pend_a, flag_due;
	logic [2:0]          stretch_cfg_i;
	logic                fetch_next_o, busy_o, exec_valid_o, debug_trap_o;
	logic                ext_rd_o, ext_we_o, acc_load_o, ext_done_o;
	ocd_pkg::ocd_dec_t   exec_dec_o;
	logic [7:0]          shadow [256];
	ocd_note_t           note_q [$];
	ocd_note_t           mon_n;
	logic [7:0]          acc_q [$];
	logic [7:0]          wr_ops [3] = '{8'hf0, 8'hf2, 8'hf3};
	logic [7:0]          rd_ops [3] = '{8'he0, 8'he2, 8'he3};
	int                  fails, check_count, cycles, seed;

	ocd_decode u_ocd_decode (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
		.instr_valid_i(instr_valid_i), .opcode_i(opcode_i), .acc_i(acc_i),
		.data_pointer_i(data_pointer_i), .r0_i(r0_i), .r1_i(r1_i), .alu_flags_i(alu_flags_i),
		.stretch_cfg_i(stretch_cfg_i), .ext_rdata_i(ext_rdata_i),
		.fetch_next_o(fetch_next_o), .busy_o(busy_o),
		.exec_valid_o(exec_valid_o), .exec_dec_o(exec_dec_o),
		.debug_trap_o(debug_trap_o), .flags_o(flags_o),
		.ext_addr_o(ext_addr_o), .ext_rd_o(ext_rd_o), .ext_we_o(ext_we_o),
		.ext_wdata_o(ext_wdata_o), .acc_load_o(acc_load_o),
		.acc_data_o(acc_data_o), .ext_done_o(ext_done_o));

	ocd_ext_mem u_ocd_ext_mem (.clk_sys_i(clk_sys_i),
		.ext_addr_i(ext_addr_o), .ext_rd_i(ext_rd_o), .ext_we_i(ext_we_o),
		.ext_wdata_i(ext_wdata_o), .ext_rdata_o(ext_rdata_i));

	////////////////////////////////////////////////////////////////////////
	// Compare, verdict and expectation helpers
	task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp)
		begin
			fails++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic report_and_stop();
		if (fails == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// Expected decode and flag outcome of one opcode
	function automatic ocd_note_t mk(input logic [7:0] o,
		input ocd_pkg::ocd_flags_t a, input ocd_pkg::ocd_flags_t f);
		ocd_note_t n;
		n.chk_op = 1'b1;
		n.chk_reg = o[7] & o[3];
		n.reg_idx = o[2:0];
		n.addr_hi = o[7:5];
		n.trap = (o == 8'ha5);
		n.flags = f;
		case (o) inside
			8'ha5: n.op = ocd_pkg::OP_TRAP;
			8'ha4: n.op = ocd_pkg::OP_MUL;
			8'h84: n.op = ocd_pkg::OP_DIV;
			8'hb4, [8'hb8:8'hbf]: n.op = ocd_pkg::OP_COMPARE_JUMP_NOT_EQUAL;
			8'ha3: n.op = ocd_pkg::OP_INC_DATA_POINTER;
			8'hb3: n.op = ocd_pkg::OP_CPL_C;
			8'hc4: n.op = ocd_pkg::OP_SWAP;
			8'hd4: n.op = ocd_pkg::OP_DA;
			8'he4: n.op = ocd_pkg::OP_CLR_A;
			8'hf4: n.op = ocd_pkg::OP_CPL_A;
			[8'h98:8'h9f]: n.op = ocd_pkg::OP_SUBTRACT_WITH_BORROW;
			[8'hc8:8'hcf]: n.op = ocd_pkg::OP_XCH;
			[8'hd8:8'hdf]: n.op = ocd_pkg::OP_DECREMENT_JUMP_NONZERO;
			[8'h88:8'h8f]: n.op = ocd_pkg::OP_MOV_DIR;
			[8'ha8:8'haf], [8'hf8:8'hff]: n.op = ocd_pkg::OP_MOV_REG;
			[8'he8:8'hef]: n.op = ocd_pkg::OP_MOV_A;
			8'hc0: n.op = ocd_pkg::OP_PUSH;
			8'hd0: n.op = ocd_pkg::OP_POP;
			8'hc2: n.op = ocd_pkg::OP_CLR_BIT;
			8'hd2: n.op = ocd_pkg::OP_SET_BIT;
			8'hb2: n.op = ocd_pkg::OP_CPL_BIT;
			8'hc3: n.op = ocd_pkg::OP_CLR_C;
			8'hd3: n.op = ocd_pkg::OP_SET_C;
			8'he0, 8'he2, 8'he3: n.op = ocd_pkg::OP_EXT_RD;
			8'hf0, 8'hf2, 8'hf3: n.op = ocd_pkg::OP_EXT_WR;
			8'b???00001: n.op = ocd_pkg::OP_ABSOLUTE_JUMP_11BIT;
			8'b???10001: n.op = ocd_pkg::OP_ABSOLUTE_CALL_11BIT;
			default: n.chk_op = 1'b0;
		endcase
		case (o) inside
			[8'h94:8'h9f]: n.flags = a;
			8'h84, 8'ha4: n.flags = {1'b0, a.overflow_flag, f.aux_carry_flag};
			8'h82, 8'ha0, 8'ha2, 8'hb0, [8'hb4:8'hbf], 8'hd4:
				n.flags.carry_flag = a.carry_flag;
			8'hc3: n.flags.carry_flag = 1'b0;
			8'hd3: n.flags.carry_flag = 1'b1;
			8'hb3: n.flags.carry_flag = ~f.carry_flag;
			default: n.flags = f;
		endcase
		return n;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Drivers: one opcode, an idle cycle, a whole external move
	task automatic issue(input logic [7:0] o);
		ocd_note_t n;
		ocd_pkg::ocd_flags_t a;
		a = 3'($random(seed));
		n = mk(o, a, exp_f);
		exp_f = n.flags;
		note_q.push_back(n);
		v_acc = 8'($random(seed));
		v_data_pointer = 16'($random(seed));
		v_r0 = 8'($random(seed)) & 8'h03;
		v_r1 = 8'($random(seed)) & 8'h03;
		@(posedge clk_sys_i);
		opcode_i <= o;
		instr_valid_i <= 1'b1;
		alu_flags_i <= pend_a; // Flags of the op now executing
		pend_a = a;
		acc_i <= v_acc;
		data_pointer_i <= v_data_pointer;
		r0_i <= v_r0;
		r1_i <= v_r1;
	endtask

	task automatic idle();
		@(posedge clk_sys_i);
		instr_valid_i <= 1'b0;
		opcode_i <= 8'($random(seed));
		alu_flags_i <= pend_a;
	endtask

	task automatic ext_move(input logic [7:0] o, input logic [2:0] s);
		logic [15:0] ad;
		int n;
		issue(o);
		stretch_cfg_i <= s;
		ad = o[1] ? {8'h00, o[0] ? v_r1 : v_r0} : v_data_pointer;
		if (!o[4])
			acc_q.push_back(shadow[ad[7:0]]);
		else
			shadow[ad[7:0]] = v_acc;
		issue(8'hc3); // Held while busy, taken once the move ends
		stretch_cfg_i <= ~s; // Change after the take must not count
		n = 0;
		do
		begin
			@(negedge clk_sys_i);
			n++;
			if (n == 1)
			begin
				chk_val(ext_addr_o, ad);
				chk_val(16'(busy_o), 16'h1);
				chk_val(16'({ext_rd_o, ext_we_o}), o[4] ? 16'h1 : 16'h2);
				if (o[4]) chk_val(16'(ext_wdata_o), 16'(shadow[ad[7:0]]));
			end
		end
		while (ext_done_o !== 1'b1 && n < 20);
		chk_val(16'({busy_o, fetch_next_o}), 16'h1);
		chk_val(16'(n), 16'(o[4] ? 4 + s : 3 + s));
		idle();
	endtask

	////////////////////////////////////////////////////////////////////////
	// Monitor: pops the oldest note whenever a result appears
	always @(negedge clk_sys_i)
	begin
		if (rst_b_i)
		begin
			chk_val(16'(fetch_next_o), 16'(instr_valid_i & ~busy_o));
			if (flag_chk) chk_val(16'(flags_o), 16'(flag_due));
			flag_chk = 1'b0;
			if (exec_valid_o === 1'b1 && note_q.size() > 0)
			begin
				mon_n = note_q.pop_front();
				if (mon_n.chk_op) chk_val(16'(exec_dec_o.op), 16'(mon_n.op));
				if (mon_n.chk_reg) chk_val(16'(exec_dec_o.opnd), 16'(ocd_pkg::OPND_REG));
				chk_val(16'(exec_dec_o.reg_idx), 16'(mon_n.reg_idx));
				chk_val(16'(exec_dec_o.addr_hi), 16'(mon_n.addr_hi));
				chk_val(16'(debug_trap_o), 16'(mon_n.trap));
				flag_due = mon_n.flags;
				flag_chk = 1'b1;
			end
			else
				chk_val(16'(debug_trap_o), 16'h0);
			if (acc_load_o === 1'b1)
				chk_val(16'(acc_data_o), acc_q.size() > 0 ? 16'(acc_q.pop_front()) : 16'hffff);
		end
	end

	// Clock and hang guard
	initial
	begin
		clk_sys_i = 1'b0;
		forever #50 clk_sys_i = ~clk_sys_i;
	end

	always @(posedge clk_sys_i)
	begin
		cycles++;
		if (cycles > 5000)
		begin
			fails++;
			report_and_stop();
		end
	end

	// Main sequence
	initial
	begin
		logic [7:0] o;
		seed = 54273;
		{rst_b_i, instr_valid_i, opcode_i, acc_i, data_pointer_i, r0_i, r1_i} = '0;
		{alu_flags_i, stretch_cfg_i, exp_f, pend_a, flag_chk} = '0;
		for (int i = 0; i < 256; i++)
			shadow[i] = 8'(i) ^ 8'h3c;
		repeat (20) @(posedge clk_sys_i);
		rst_b_i <= 1'b1;
		issue(8'ha5);
		issue(8'ha5);
		for (int i = 0; i < 300; i++)
		begin
			o = 8'h80 | 8'($random(seed));
			if (o inside {8'he0, 8'he2, 8'he3, 8'hf0, 8'hf2, 8'hf3})
				o = 8'ha5;
			issue(o);
			if (i % 7 == 0)
				idle();
		end
		idle();
		for (int s = 0; s < 8; s++)
		begin
			ext_move(wr_ops[s % 3], 3'(s));
			ext_move(rd_ops[s % 3], 3'(7 - s));
		end
		repeat (4) idle();
		chk_val(16'(note_q.size() + acc_q.size()), 16'h0);
		report_and_stop();
	end
endmodule
